// *** tcp_defs.vh ***
// Shared constants for the cascadable PWM and phase counting timer pair
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH

// Counter width
`define TCP_W          16

// PWM mode select
`define TCP_PWM_OFF    2'h0
`define TCP_PWM_1      2'h1
`define TCP_PWM_2      2'h2

// Pin action at compare match
`define TCP_ACT_NONE   2'h0
`define TCP_ACT_LOW    2'h1
`define TCP_ACT_HIGH   2'h2
`define TCP_ACT_TOG    2'h3

// Counter clear source
`define TCP_CLR_NONE   2'h0
`define TCP_CLR_A      2'h1
`define TCP_CLR_B      2'h2

// Phase counting sub-modes
`define TCP_PH_1       2'h0
`define TCP_PH_2       2'h1
`define TCP_PH_3       2'h2
`define TCP_PH_4       2'h3

// Capture edge select
`define TCP_EDGE_RISE  2'h1
`define TCP_EDGE_FALL  2'h2
`define TCP_EDGE_BOTH  2'h3

// Clock source code that selects the lower counter's carry
`define TCP_CLKSRC_CASC 3'h7

// Status flag bit positions
`define TCP_FLG_A      0
`define TCP_FLG_B      1
`define TCP_FLG_OVF    2
`define TCP_FLG_UDF    3
`define TCP_NFLG       4

`endif

// *** tcp_enc_model.sv ***
// Two-phase encoder model that drives one pair of phase inputs
module tcp_enc_model (
  // Clock and reset
  input  wire ref_clk,
  input  wire rst_n,
  // Step control
  input  wire req,
  input  wire fwd,
  // Phase outputs
  output wire ph_a,
  output wire ph_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pos_q;

  // One step per requested cycle, AB order 00 10 11 01
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      pos_q <= 2'h0;
    else if (req)
      pos_q <= fwd ? pos_q + 2'h1 : pos_q - 2'h1;
  end
  assign ph_a = pos_q[0] ^ pos_q[1];
  assign ph_b = pos_q[1];
endmodule // tcp_enc_model

// *** tcp_testbench.sv ***
// Self-checking bench for the cascadable timer pair
`include "tcp_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_n, req_ab, fwd_ab, req_cd, fwd_cd;
  logic [1:0]  run, phase_on, init_a, init_b, pin_a_in, pin_b_in, cnt_wr, gr_a_wr, gr_b_wr;
  logic [2:0]  clk_src;
  logic [3:0]  phase_sub, pwm_mode, clear_sel, cap_mode, edge_a, edge_b, act_a, act_b;
  logic [15:0] wdata;
  logic [7:0]  int_en, flag_clr;
  wire         ph_a, ph_b, ph_c, ph_d;
  wire  [1:0]  pa_out, pa_oe, pb_out, pb_oe, dir, irq;
  wire  [7:0]  status;
  wire  [31:0] cnt, gra, grb;
  int          n_fail, samples_checked, h;

  // Upper channel takes A/B phases, lower C/D
  tcp_enc_model u_enc_ab (.ref_clk(ref_clk), .rst_n(rst_n), .req(req_ab), .fwd(fwd_ab),
    .ph_a(ph_a), .ph_b(ph_b));
  tcp_enc_model u_enc_cd (.ref_clk(ref_clk), .rst_n(rst_n), .req(req_cd), .fwd(fwd_cd),
    .ph_a(ph_c), .ph_b(ph_d));
  tcp_top u_tcp_top (.ref_clk(ref_clk), .rst_n(rst_n), .ext_clock_in_a(ph_a),
    .ext_clock_in_b(ph_b), .ext_clock_in_c(ph_c), .ext_clock_in_d(ph_d), .run(run),
    .clock_source_select(clk_src), .phase_on(phase_on), .phase_sub(phase_sub),
    .pwm_mode(pwm_mode), .clear_sel(clear_sel), .cap_mode(cap_mode), .edge_a(edge_a),
    .edge_b(edge_b), .pin_a_action_field(act_a), .pin_b_action_field(act_b),
    .init_a(init_a), .init_b(init_b), .capture_compare_pin_a_in(pin_a_in),
    .capture_compare_pin_b_in(pin_b_in), .capture_compare_pin_a_out(pa_out),
    .capture_compare_pin_a_oe(pa_oe), .capture_compare_pin_b_out(pb_out),
    .capture_compare_pin_b_oe(pb_oe), .cnt_wr(cnt_wr), .gr_a_wr(gr_a_wr),
    .gr_b_wr(gr_b_wr), .wdata(wdata), .interrupt_enable_reg(int_en), .flag_clr(flag_clr),
    .channel_status_reg(status), .count_direction_flag(dir), .irq(irq),
    .channel_counter(cnt), .general_reg_a(gra), .general_reg_b(grb));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Kind 0 counter, 1 reg A, 2 reg B
  task automatic wr(input int kind, input int ch, input logic [15:0] v);
    @(negedge ref_clk);
    wdata = v;
    if (kind == 0)
      cnt_wr[ch] = 1'b1;
    else if (kind == 1)
      gr_a_wr[ch] = 1'b1;
    else
      gr_b_wr[ch] = 1'b1;
    @(negedge ref_clk);
    cnt_wr = 2'h0;
    gr_a_wr = 2'h0;
    gr_b_wr = 2'h0;
  endtask

  task automatic step(input bit cd, input bit fwd, input int n);
    @(negedge ref_clk);
    fwd_ab = fwd;
    fwd_cd = fwd;
    req_ab = !cd;
    req_cd = cd;
    repeat (n) @(negedge ref_clk);
    req_ab = 1'b0;
    req_cd = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic highs(input int ch, input int n);
    h = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      if (pa_out[ch] === 1'b1)
        h++;
    end
  endtask

  task automatic t_phase;
    int d [8] = '{8, 2, 2, 4, -8, -2, -2, -4};
    for (int k = 0; k < 8; k++)
    begin
      run = 2'h0;
      phase_on = 2'h2;
      phase_sub[3:2] = k[1:0];
      wr(0, 1, 16'h8000);
      run = 2'h2;
      step(0, k < 4, 8);
      check(cnt[31:16], 16'h8000 + d[k]);
      check(dir[1], k < 4);
    end
  endtask

  task automatic t_casc;
    clk_src = `TCP_CLKSRC_CASC;
    phase_on = 2'h0;
    run = 2'h0;
    wr(0, 0, 16'hFFFD);
    wr(0, 1, 16'h0010);
    run = 2'h3;
    repeat (4) @(negedge ref_clk);
    run = 2'h0;
    check(cnt, 32'h00110001);
    check(status[2], 1'b1);
    phase_on = 2'h1;
    phase_sub = 4'h0;
    wr(0, 0, 16'h0000);
    wr(0, 1, 16'h0020);
    run = 2'h3;
    step(1, 0, 1);
    check(cnt, 32'h001FFFFF);
    check({status[3], dir[0]}, 2'b10);
    step(1, 1, 1);
    check(cnt, 32'h00200000);
    phase_on = 2'h3;
    step(1, 0, 1);
    check(cnt, 32'h0020FFFF);
    step(1, 1, 1);
  endtask

  task automatic t_capture;
    phase_on = 2'h1;
    wr(0, 0, 16'h1234);
    wr(0, 1, 16'hABCD);
    cap_mode = 4'h5;
    edge_a = 4'h5;
    int_en = 8'h01;
    flag_clr = 8'hFF;
    @(negedge ref_clk);
    flag_clr = 8'h00;
    pin_a_in = 2'h3;
    repeat (2) @(negedge ref_clk);
    check(gra, 32'hABCD1234);
    check({status[4], status[0], irq}, 4'b1101);
    flag_clr = 8'h01;
    @(negedge ref_clk);
    flag_clr = 8'h00;
    @(negedge ref_clk);
    check({status[0], irq[0]}, 2'b00);
    cap_mode = 4'h0;
    int_en = 8'h00;
    run = 2'h0;
  endtask

  task automatic t_pwm1;
    clk_src = 3'h0;
    phase_on = 2'h0;
    pwm_mode = 4'h1;
    clear_sel = 4'h1;
    act_a = 4'h2;
    act_b = 4'h1;
    init_a = 2'h1;
    wr(1, 0, 16'h0009);
    wr(2, 0, 16'h0004);
    wr(0, 0, 16'h0000);
    check({pa_out[0], pb_oe[0]}, 2'b10);
    run = 2'h1;
    highs(0, 10);
    highs(0, 20);
    check(h, 10);
    run = 2'h0;
    act_a = 4'h1;
    wr(2, 0, 16'h0009);
    run = 2'h1;
    highs(0, 20);
    check(h, 20);
    run = 2'h0;
  endtask

  task automatic t_pwm2;
    pwm_mode = 4'h8;
    clear_sel = 4'h8;
    act_a = 4'h4;
    init_a = 2'h2;
    init_b = 2'h2;
    wr(2, 1, 16'h0007);
    wr(1, 1, 16'h0003);
    wr(0, 1, 16'h0000);
    run = 2'h2;
    highs(1, 8);
    highs(1, 16);
    check(h, 8);
    check({pa_oe[1], pb_oe[1]}, 2'b10);
    check(pb_out[1], 1'b1);
    check(grb[31:16], 16'h0007);
    run = 2'h0;
    wr(1, 1, 16'h0007);
    run = 2'h2;
    highs(1, 16);
    check(h, 16);
    run = 2'h0;
    pwm_mode = 4'h0;
    clear_sel = 4'h1;
    act_a = 4'h3;
    wr(1, 0, 16'h0004);
    wr(0, 0, 16'h0000);
    run = 2'h1;
    highs(0, 10);
    highs(0, 20);
    check(h, 10);
    run = 2'h0;
  endtask

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    complete_run;
  end

  initial
  begin
    {rst_n, req_ab, fwd_ab, req_cd, fwd_cd, run, phase_on, init_a, init_b} = 0;
    {pin_a_in, pin_b_in, cnt_wr, gr_a_wr, gr_b_wr, clk_src, phase_sub, pwm_mode} = 0;
    {clear_sel, cap_mode, edge_a, edge_b, act_a, act_b, wdata, int_en, flag_clr} = 0;
    n_fail = 0;
    samples_checked = 0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    check(cnt, 32'h0);
    check(gra, 32'hFFFFFFFF);
    check({20'h00000, status, dir, irq}, 32'h00000000);
    t_phase;
    t_casc;
    t_capture;
    t_pwm1;
    t_pwm2;
    complete_run;
  end
endmodule // testbench

// *** tcp_top.v ***
// Cascadable timer pair with PWM output and quadrature phase counting
`include "tcp_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Two 16-bit channel counters join into one 32-bit count.
// - Upper counter advances on lower carry when clock source selects cascade.
// - Lower counter passes underflow carry only while phase counting.
// - Phase counting on upper channel overrides the cascade clock selection.
// - Simultaneous capture stores upper half upstairs, lower half downstairs.
// - Upper counter increments on lower overflow, decrements on lower underflow.
// - Compare match drives pin low, high or toggled per action field.
// - Duty from 0% to 100% is set through general registers; 0% and 100% also take the initial pin level.
// - Clear-source register sets the period; each channel configured independently.
// - PWM mode 1 drives pin A from A match and B match levels.
// - PWM mode 1 pin sits at initial A level before any match.
// - PWM mode 1 holds pin when both paired registers are equal.
// - PWM mode 1 gives one phase per pair; two across both channels.
// - PWM mode 2 cycle match clears counter, returns pins to initial level.
// - PWM mode 2 duty equal to cycle leaves that pin unchanged.
// - PWM mode 2 cycle register produces no output on its pin.
// - Phase counting only where allowed, ignoring prescaler and edge select.
// - Clear, pin control, enables and capture/compare keep working in phase mode.
// - Phase mode sets overflow and underflow flags and shows direction.
// - Channel 1 uses inputs A/B; channel 0 uses inputs C/D (swapped when UPPER_1 is 0).
// - Sub-mode 1 counts on every edge of both phases.
// - Sub-mode 2 counts only on A falling, direction from B.
// - Sub-mode 3 counts up on A fall, down on B fall.
// - Sub-mode 4 counts on B edges only, direction from A.
// - Events set sticky flags; enabled flags raise interrupt; clear withdraws.
module tcp_chan #(
  parameter W        = `TCP_W,
  parameter PHASE_OK = 1
) (
  // Clock and reset
  input  wire                ref_clk,
  input  wire                rst_n,
  // Mode control
  input  wire                run,
  input  wire                phase_on,
  input  wire [1:0]          phase_sub,
  input  wire [1:0]          pwm_mode,
  input  wire [1:0]          clear_sel,
  input  wire                casc_on,
  // Count sources
  input  wire                carry_up,
  input  wire                carry_dn,
  input  wire                ph_a,
  input  wire                ph_b,
  // Pin control
  input  wire [1:0]          cap_mode,
  input  wire [1:0]          edge_a,
  input  wire [1:0]          edge_b,
  input  wire [1:0]          act_a,
  input  wire [1:0]          act_b,
  input  wire                init_a,
  input  wire                init_b,
  input  wire                pin_a_in,
  input  wire                pin_b_in,
  // Register writes
  input  wire                cnt_wr,
  input  wire                gr_a_wr,
  input  wire                gr_b_wr,
  input  wire [W-1:0]        wdata,
  // Flags
  input  wire [`TCP_NFLG-1:0] int_en,
  input  wire [`TCP_NFLG-1:0] flag_clr,
  // Results
  output reg  [W-1:0]        cnt_q,
  output reg  [W-1:0]        gr_a_q,
  output reg  [W-1:0]        gr_b_q,
  output reg                 pin_a_q,
  output reg                 pin_a_oe_q,
  output reg                 pin_b_q,
  output reg                 pin_b_oe_q,
  output reg  [`TCP_NFLG-1:0] flags_q,
  output reg                 dir_q,
  output reg                 irq_q,
  output wire                ovf_carry,
  output wire                udf_carry
);

  reg                 pa_q;
  reg                 pb_q;
  reg                 ca_q;
  reg                 cb_q;
  reg                 ph_up;
  reg                 ph_dn;
  reg                 up;
  reg                 dn;
  reg  [W-1:0]        cnt_d;
  reg                 pin_a_d;
  reg                 pin_b_d;
  wire [`TCP_NFLG-1:0] flags_d;
  wire [`TCP_NFLG-1:0] ev;
  wire                a_rise;
  wire                a_fall;
  wire                b_rise;
  wire                b_fall;
  wire                phase_act;
  wire                tick;
  wire                match_a;
  wire                match_b;
  wire                cap_a;
  wire                cap_b;
  wire                clr;
  wire                pwm2;
  wire                cyc_a;
  wire                cyc_b;
  wire                cyc_any;
  wire                cyc_match;
  wire [W-1:0]        cyc_val;
  wire                at_max;
  wire                at_zero;

  ////////////////////////////////////////////////////////////////////////////
  // Level for a pin action
  function act_lvl;
    input [1:0] act;
    input       cur;
    begin
      case (act)
        `TCP_ACT_LOW:  act_lvl = 1'b0;
        `TCP_ACT_HIGH: act_lvl = 1'b1;
        `TCP_ACT_TOG:  act_lvl = ~cur;
        default:       act_lvl = cur;
      endcase
    end
  endfunction

  // Edge select match
  function edge_hit;
    input [1:0] sel;
    input       now;
    input       was;
    begin
      edge_hit = (sel[0] & now & ~was) | (sel[1] & ~now & was);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Phase edge detection
  assign a_rise = ph_a & ~pa_q;
  assign a_fall = ~ph_a & pa_q;
  assign b_rise = ph_b & ~pb_q;
  assign b_fall = ~ph_b & pb_q;
  // phase mode only on capable channels
  assign phase_act = phase_on & (PHASE_OK != 0);

  always @*
  begin
    ph_up = 1'b0;
    ph_dn = 1'b0;
    case (phase_sub)
      `TCP_PH_1:
      begin
        ph_up = (b_rise & ph_a) | (b_fall & ~ph_a) | (a_rise & ~ph_b) | (a_fall & ph_b);
        ph_dn = (b_rise & ~ph_a) | (b_fall & ph_a) | (a_rise & ph_b) | (a_fall & ~ph_b);
      end
      `TCP_PH_2:
      begin
        ph_up = a_fall & ph_b;
        ph_dn = a_fall & ~ph_b;
      end
      `TCP_PH_3:
      begin
        // A fall up, B fall down
        ph_up = a_fall & ph_b;
        ph_dn = b_fall & ph_a;
      end
      `TCP_PH_4:
      begin
        ph_up = (b_rise & ph_a) | (b_fall & ~ph_a);
        ph_dn = (b_fall & ph_a) | (b_rise & ~ph_a);
      end
      default:
      begin
        ph_up = 1'b0;
        ph_dn = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count source
  always @*
  begin
    up = 1'b0;
    dn = 1'b0;
    if (run)
    begin
      if (phase_act)
      begin
        up = ph_up & ~ph_dn;
        dn = ph_dn & ~ph_up;
      end
      else if (casc_on)
      begin
        // up on overflow, down on underflow
        up = carry_up & ~carry_dn;
        dn = carry_dn & ~carry_up;
      end
      else
        up = 1'b1;
    end
  end

  assign tick    = up | dn;
  assign at_max  = (cnt_q == {W{1'b1}});
  assign at_zero = (cnt_q == {W{1'b0}});

  // compare and capture regardless of counting source
  assign match_a = ~cap_mode[0] & tick & (cnt_q == gr_a_q);
  assign match_b = ~cap_mode[1] & tick & (cnt_q == gr_b_q);
  assign cap_a   = cap_mode[0] & edge_hit(edge_a, pin_a_in, ca_q);
  assign cap_b   = cap_mode[1] & edge_hit(edge_b, pin_b_in, cb_q);

  assign clr = ((clear_sel == `TCP_CLR_A) & (match_a | cap_a)) |
               ((clear_sel == `TCP_CLR_B) & (match_b | cap_b));

  // carries chain two counters into one
  assign ovf_carry = up & at_max & ~clr;
  // underflow carry only from a phase counter
  assign udf_carry = dn & at_zero & ~clr & phase_act;

  always @*
  begin
    cnt_d = cnt_q;
    if (cnt_wr)
      cnt_d = wdata;
    else if (clr)
      cnt_d = {W{1'b0}};
    else if (up)
      cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
    else if (dn)
      cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin waveform
  assign pwm2      = (pwm_mode == `TCP_PWM_2);
  assign cyc_a     = pwm2 & (clear_sel == `TCP_CLR_A);
  assign cyc_b     = pwm2 & (clear_sel == `TCP_CLR_B);
  assign cyc_any   = cyc_a | cyc_b;
  assign cyc_val   = cyc_b ? gr_b_q : gr_a_q;
  assign cyc_match = (cyc_a & match_a) | (cyc_b & match_b);

  always @*
  begin
    pin_a_d = pin_a_q;
    pin_b_d = pin_b_q;
    if (~run)
    begin
      pin_a_d = init_a;
      pin_b_d = init_b;
    end
    else
      case (pwm_mode)
        `TCP_PWM_1:
        begin
          if (gr_a_q != gr_b_q)
          begin
            // A level at A match, B level at B match
            if (match_a)
              pin_a_d = act_lvl(act_a, pin_a_q);
            else if (match_b)
              pin_a_d = act_lvl(act_b, pin_a_q);
          end
          pin_b_d = init_b;
        end
        `TCP_PWM_2:
        begin
          if (cyc_match)
          begin
            // duty equal to cycle keeps its level
            pin_a_d = (gr_a_q == cyc_val) ? pin_a_q : init_a;
            pin_b_d = (gr_b_q == cyc_val) ? pin_b_q : init_b;
          end
          else
          begin
            if (match_a & ~(cyc_any & (gr_a_q == cyc_val)))
              pin_a_d = act_lvl(act_a, pin_a_q);
            if (match_b & ~(cyc_any & (gr_b_q == cyc_val)))
              pin_b_d = act_lvl(act_b, pin_b_q);
          end
          if (cyc_a)
            pin_a_d = init_a;
          if (cyc_b)
            pin_b_d = init_b;
        end
        default:
        begin
          if (match_a)
            pin_a_d = act_lvl(act_a, pin_a_q);
          if (match_b)
            pin_b_d = act_lvl(act_b, pin_b_q);
        end
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and flags
  // overflow and underflow flags on wrap
  assign ev[`TCP_FLG_A]   = match_a | cap_a;
  assign ev[`TCP_FLG_B]   = match_b | cap_b;
  assign ev[`TCP_FLG_OVF] = up & at_max & ~cnt_wr;
  assign ev[`TCP_FLG_UDF] = dn & at_zero & ~cnt_wr;
  assign flags_d = (flags_q & ~flag_clr) | ev;

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_q      <= {W{1'b0}};
      gr_a_q     <= {W{1'b1}};
      gr_b_q     <= {W{1'b1}};
      pin_a_q    <= 1'b0;
      pin_b_q    <= 1'b0;
      pin_a_oe_q <= 1'b0;
      pin_b_oe_q <= 1'b0;
      flags_q    <= {`TCP_NFLG{1'b0}};
      dir_q      <= 1'b0;
      irq_q      <= 1'b0;
      pa_q       <= 1'b0;
      pb_q       <= 1'b0;
      ca_q       <= 1'b0;
      cb_q       <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      pin_a_q <= pin_a_d;
      pin_b_q <= pin_b_d;
      pa_q    <= ph_a;
      pb_q    <= ph_b;
      ca_q    <= pin_a_in;
      cb_q    <= pin_b_in;
      // capture stores this channel's own half
      if (gr_a_wr)
        gr_a_q <= wdata;
      else if (cap_a)
        gr_a_q <= cnt_q;
      if (gr_b_wr)
        gr_b_q <= wdata;
      else if (cap_b)
        gr_b_q <= cnt_q;
      pin_a_oe_q <= ~cap_mode[0] & ~cyc_a;
      pin_b_oe_q <= ~cap_mode[1] & ~cyc_b & (pwm_mode != `TCP_PWM_1);
      flags_q    <= flags_d;
      if (phase_act & tick)
        dir_q <= up;
      irq_q <= |(flags_d & int_en);
    end
  end

endmodule // tcp_chan

////////////////////////////////////////////////////////////////////////////////
// Cascade pair: index 1 is the upper channel, index 0 the lower
module tcp_top #(
  parameter W       = `TCP_W,
  parameter UPPER_1 = 1
) (
  // Clock and reset
  input  wire                  ref_clk,
  input  wire                  rst_n,
  // External phase inputs
  input  wire                  ext_clock_in_a,
  input  wire                  ext_clock_in_b,
  input  wire                  ext_clock_in_c,
  input  wire                  ext_clock_in_d,
  // Channel control, [1] upper [0] lower
  input  wire [1:0]            run,
  input  wire [2:0]            clock_source_select,
  input  wire [1:0]            phase_on,
  input  wire [3:0]            phase_sub,
  input  wire [3:0]            pwm_mode,
  input  wire [3:0]            clear_sel,
  input  wire [3:0]            cap_mode,
  input  wire [3:0]            edge_a,
  input  wire [3:0]            edge_b,
  input  wire [3:0]            pin_a_action_field,
  input  wire [3:0]            pin_b_action_field,
  input  wire [1:0]            init_a,
  input  wire [1:0]            init_b,
  // Capture/compare pins
  input  wire [1:0]            capture_compare_pin_a_in,
  input  wire [1:0]            capture_compare_pin_b_in,
  output wire [1:0]            capture_compare_pin_a_out,
  output wire [1:0]            capture_compare_pin_a_oe,
  output wire [1:0]            capture_compare_pin_b_out,
  output wire [1:0]            capture_compare_pin_b_oe,
  // Register writes
  input  wire [1:0]            cnt_wr,
  input  wire [1:0]            gr_a_wr,
  input  wire [1:0]            gr_b_wr,
  input  wire [W-1:0]          wdata,
  // Status
  input  wire [2*`TCP_NFLG-1:0] interrupt_enable_reg,
  input  wire [2*`TCP_NFLG-1:0] flag_clr,
  output wire [2*`TCP_NFLG-1:0] channel_status_reg,
  output wire [1:0]            count_direction_flag,
  output wire [1:0]            irq,
  // Counters and general registers, upper half first
  output wire [2*W-1:0]        channel_counter,
  output wire [2*W-1:0]        general_reg_a,
  output wire [2*W-1:0]        general_reg_b
);

  wire [1:0] ovf_c;
  wire [1:0] udf_c;
  wire [1:0] pa;
  wire [1:0] pb;

  // phase input routing per channel number
  assign pa[1] = UPPER_1 ? ext_clock_in_a : ext_clock_in_c;
  assign pb[1] = UPPER_1 ? ext_clock_in_b : ext_clock_in_d;
  assign pa[0] = UPPER_1 ? ext_clock_in_c : ext_clock_in_a;
  assign pb[0] = UPPER_1 ? ext_clock_in_d : ext_clock_in_b;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_ch
      tcp_chan #(.W(W), .PHASE_OK(1)) u_ch (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .run        (run[i]),
        .phase_on   (phase_on[i]),
        .phase_sub  (phase_sub[2*i+1:2*i]),
        .pwm_mode   (pwm_mode[2*i+1:2*i]),
        .clear_sel  (clear_sel[2*i+1:2*i]),
        .casc_on    ((i == 1) && (clock_source_select == `TCP_CLKSRC_CASC)),
        .carry_up   ((i == 1) ? ovf_c[0] : 1'b0),
        .carry_dn   ((i == 1) ? udf_c[0] : 1'b0),
        .ph_a       (pa[i]),
        .ph_b       (pb[i]),
        .cap_mode   (cap_mode[2*i+1:2*i]),
        .edge_a     (edge_a[2*i+1:2*i]),
        .edge_b     (edge_b[2*i+1:2*i]),
        .act_a      (pin_a_action_field[2*i+1:2*i]),
        .act_b      (pin_b_action_field[2*i+1:2*i]),
        .init_a     (init_a[i]),
        .init_b     (init_b[i]),
        .pin_a_in   (capture_compare_pin_a_in[i]),
        .pin_b_in   (capture_compare_pin_b_in[i]),
        .cnt_wr     (cnt_wr[i]),
        .gr_a_wr    (gr_a_wr[i]),
        .gr_b_wr    (gr_b_wr[i]),
        .wdata      (wdata),
        .int_en     (interrupt_enable_reg[`TCP_NFLG*i+`TCP_NFLG-1:`TCP_NFLG*i]),
        .flag_clr   (flag_clr[`TCP_NFLG*i+`TCP_NFLG-1:`TCP_NFLG*i]),
        .cnt_q      (channel_counter[W*i+W-1:W*i]),
        .gr_a_q     (general_reg_a[W*i+W-1:W*i]),
        .gr_b_q     (general_reg_b[W*i+W-1:W*i]),
        .pin_a_q    (capture_compare_pin_a_out[i]),
        .pin_a_oe_q (capture_compare_pin_a_oe[i]),
        .pin_b_q    (capture_compare_pin_b_out[i]),
        .pin_b_oe_q (capture_compare_pin_b_oe[i]),
        .flags_q    (channel_status_reg[`TCP_NFLG*i+`TCP_NFLG-1:`TCP_NFLG*i]),
        .dir_q      (count_direction_flag[i]),
        .irq_q      (irq[i]),
        .ovf_carry  (ovf_c[i]),
        .udf_carry  (udf_c[i])
      );
    end
  endgenerate

endmodule // tcp_top

// *** tcp_top_properties.sv ***
// Concurrent checks on the timer pair ports
`include "tcp_defs.vh"
module tcp_top_props #(
  parameter W = `TCP_W
) (
  input wire                    ref_clk,
  input wire                    rst_n,
  input wire                    ext_clock_in_a,
  input wire                    ext_clock_in_b,
  input wire                    ext_clock_in_c,
  input wire                    ext_clock_in_d,
  input wire [1:0]              run,
  input wire [2:0]              clock_source_select,
  input wire [1:0]              phase_on,
  input wire [3:0]              phase_sub,
  input wire [3:0]              pwm_mode,
  input wire [3:0]              clear_sel,
  input wire [1:0]              cnt_wr,
  input wire [2*`TCP_NFLG-1:0]  interrupt_enable_reg,
  input wire [2*`TCP_NFLG-1:0]  flag_clr,
  input wire [2*`TCP_NFLG-1:0]  channel_status_reg,
  input wire [1:0]              count_direction_flag,
  input wire [1:0]              irq,
  input wire [2*W-1:0]          channel_counter,
  input wire [1:0]              capture_compare_pin_b_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire lo_norm = run[0] && !phase_on[0] && !cnt_wr[0] && clear_sel[1:0] == 2'h0;
  wire casc    = run[1] && clock_source_select == 3'h7 && !phase_on[1] && !cnt_wr[1]
                 && clear_sel[3:2] == 2'h0;
  wire [15:0] lo = channel_counter[15:0];
  wire [15:0] up = channel_counter[31:16];

  casc_carry_a: assert property (casc && lo_norm && lo == 16'hFFFF
    |=> up == $past(up) + 16'h1) else $error("upper missed lower carry");
  casc_hold_a: assert property (casc && !phase_on[0] && lo != 16'hFFFF
    |=> $stable(up)) else $error("upper moved without carry");
  casc_borrow_a: assert property (casc && !cnt_wr[0] && lo == 16'h0 ##1 lo == 16'hFFFF
    |-> up == $past(up) - 16'h1) else $error("upper missed lower borrow");
  ovf_flag_a: assert property (lo_norm && lo == 16'hFFFF
    |=> channel_status_reg[2]) else $error("overflow flag not set");
  irq_follow_a: assert property (irq[0] ==
    |(channel_status_reg[3:0] & $past(interrupt_enable_reg[3:0])))
    else $error("request differs from enabled flags");
  flag_sticky_a: assert property (channel_status_reg[0] && !flag_clr[0]
    |=> channel_status_reg[0]) else $error("flag dropped without clear");
  cycle_pin_a: assert property (pwm_mode[3:2] == 2'h2 && clear_sel[3:2] == 2'h2
    |=> !capture_compare_pin_b_oe[1]) else $error("cycle pin driven");
  pair_pin_a: assert property (pwm_mode[1:0] == 2'h1
    |=> !capture_compare_pin_b_oe[0]) else $error("paired pin driven");
  phase_idle_a: assert property (run[0] && phase_on[0] && !cnt_wr[0]
    && clear_sel[1:0] == 2'h0 && $stable(ext_clock_in_c) && $stable(ext_clock_in_d)
    |=> $stable(lo)) else $error("phase counter moved without edge");
  dir_up_a: assert property (run[1] && phase_on[1] && phase_sub[3:2] == 2'h0
    && $rose(ext_clock_in_a) && !ext_clock_in_b |=> count_direction_flag[1])
    else $error("direction not up");
  dir_down_a: assert property (run[1] && phase_on[1] && phase_sub[3:2] == 2'h0
    && $fell(ext_clock_in_a) && !ext_clock_in_b |=> !count_direction_flag[1])
    else $error("direction not down");
endmodule // tcp_top_props

bind tcp_top tcp_top_props #(.W(W)) u_tcp_top_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .ext_clock_in_a(ext_clock_in_a),
  .ext_clock_in_b(ext_clock_in_b), .ext_clock_in_c(ext_clock_in_c),
  .ext_clock_in_d(ext_clock_in_d), .run(run), .clock_source_select(clock_source_select),
  .phase_on(phase_on), .phase_sub(phase_sub), .pwm_mode(pwm_mode), .clear_sel(clear_sel),
  .cnt_wr(cnt_wr), .interrupt_enable_reg(interrupt_enable_reg), .flag_clr(flag_clr),
  .channel_status_reg(channel_status_reg), .count_direction_flag(count_direction_flag),
  .irq(irq), .channel_counter(channel_counter),
  .capture_compare_pin_b_oe(capture_compare_pin_b_oe)
);
